/* rtl/ecit_top.sv */
// Edge capture channels, free-running counter and interval timer registers.
// Assumes an Avalon-MM master on i_core_clk; capture pins are asynchronous.
//
// Operation
// - 8-bit mode: channel-1 falling register loads selected counter bits on falling edge.
// - 16-bit mode: channel-1 falling register takes upper counter byte at channel-0 fall.
// - Count low byte is read-only; reading it holds the upper nibble.
// - Count high register returns held nibble in bits 3..0, zeros above.
// - Two channels, each with separate rising and falling capture registers.
// - Joined mode: channel 1 holds high byte, channel 0 low byte.
// - Each of the four capture loads can raise an interrupt, own enable.
// - Hold bit clear: every qualifying edge overwrites the capture register.
// - Hold bit set: keep the first edge until the register is read.
// - 8-bit mode: prescale n selects counter bits n+7 down to n.
// - Wide enable bit 3 turns channel 1 into channel-0 upper extension.
// - Enable bits 0..3 gate c0 rise, c0 fall, c1 rise, c1 fall.
// - Status bits 0..3 set on c0 rise, c0 fall, c1 rise, c1 fall.
// - Writing one clears status; a set bit keeps its enabled interrupt asserted until cleared.
// - Captures come from a 16-bit free-running counter on the capture clock.
// - Channel-0 registers record latest edges, or the first with hold set; low byte in 16-bit mode.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module ecit_top
import ecit_pkg::*;
#(
    parameter int CAP_DIV = ecit_pkg::ECIT_CAP_CLK_DIV,
    parameter int PIT_DIV = ecit_pkg::ECIT_PIT_DIV
)
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [ecit_pkg::ECIT_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_capture_input_zero,
    input wire logic i_capture_input_one,
    output logic o_irq
);
    import ecit_pkg::*;

    typedef struct packed {
        ecit_bus_e bus;
        logic [31:0] rdata;
        logic [7:0] cap_div;
        logic [7:0] pit_div;
        logic [15:0] frc;
        logic [7:0] c0r;
        logic [7:0] c1r;
        logic [7:0] c0f;
        logic [7:0] c1f;
        logic [3:0] full;
        logic [3:0] held_nib;
        logic [7:0] rld_lo;
        logic [3:0] rld_hi;
        logic [7:0] cfg;
        logic [3:0] irq_en;
        logic [3:0] irq_st;
        logic pit_en;
        logic pit_st;
        logic irq;
    } ecit_top_s;

    ecit_top_s st_q;
    ecit_top_s st_d;
    logic c0_rise;
    logic c0_fall;
    logic c1_rise;
    logic c1_fall;
    logic pit_tick;
    logic [ECIT_PIT_W-1:0] pit_count;
    logic pit_expire;

    // Dividers count in eight bits, so larger values cannot be served
    if (CAP_DIV < 1 || CAP_DIV > 255 || PIT_DIV < 1 || PIT_DIV > 255)
    begin : g_bad_div
        $error("Divider out of range");
    end

    // ==========================================================
    // Input edges
    ecit_edge_sync u_sync0
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_pin(i_capture_input_zero),
        .o_rise(c0_rise),
        .o_fall(c0_fall)
    );
    ecit_edge_sync u_sync1
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_pin(i_capture_input_one),
        .o_rise(c1_rise),
        .o_fall(c1_fall)
    );

    assign pit_tick = (st_q.pit_div == 8'(PIT_DIV - 1));

    ecit_interval_timer #(.WIDTH(ECIT_PIT_W)) u_pit
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_tick(pit_tick),
        .i_reload({st_q.rld_hi, st_q.rld_lo}),
        .o_count(pit_count),
        .o_expire(pit_expire)
    );

    // ==========================================================
    // Helpers
    function automatic logic [7:0] sel_bits(input logic [15:0] frc, input logic [2:0] n);
        logic [15:0] sh;
        sh = frc >> n;
        return sh[7:0];
    endfunction

    function automatic logic is_idx(input logic [ECIT_ADDR_W-1:0] a, input logic [7:0] idx);
        return (a[ECIT_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    // ==========================================================
    // Next state
    always_comb
    begin
        logic [3:0] ev;
        logic [3:0] rd_clr;
        logic [7:0] pick;
        logic [7:0] wb;
        logic wide;
        logic hold;
        logic acc;
        logic rd;
        logic wr;
        ev = 4'h0;
        rd_clr = 4'h0;
        pick = 8'h00;
        wb = i_avs_writedata[7:0];
        st_d = st_q;
        wide = st_q.cfg[ECIT_CFG_WIDE_BIT];
        hold = st_q.cfg[ECIT_CFG_HOLD_BIT];
        acc = (st_q.bus == ECIT_BUS_IDLE) && (i_avs_read || i_avs_write);
        rd = acc && i_avs_read;
        // A write commits at the acknowledge edge, where the master samples waitrequest low
        wr = (st_q.bus == ECIT_BUS_ACK) && i_avs_write && i_avs_byteenable[0];
        wr = wr && (i_avs_address[1:0] == 2'b00);

        // Capture clock enable drives the counter
        if (st_q.cap_div == 8'(CAP_DIV - 1))
        begin
            st_d.cap_div = 8'h00;
            st_d.frc = st_q.frc + 16'h0001;
        end
        else
        begin
            st_d.cap_div = st_q.cap_div + 8'h01;
        end
        if (pit_tick)
        begin
            st_d.pit_div = 8'h00;
        end
        else
        begin
            st_d.pit_div = st_q.pit_div + 8'h01;
        end

        // A read frees a held register for the next edge
        if (rd)
        begin
            rd_clr[ECIT_EV_C0R] = is_idx(i_avs_address, ECIT_IDX_C0_RISE);
            rd_clr[ECIT_EV_C0F] = is_idx(i_avs_address, ECIT_IDX_C0_FALL);
            rd_clr[ECIT_EV_C1R] = is_idx(i_avs_address, ECIT_IDX_C1_RISE);
            rd_clr[ECIT_EV_C1F] = is_idx(i_avs_address, ECIT_IDX_C1_FALL);
        end

        // Load gating: in joined mode channel 1 follows channel 0 edges
        ev[ECIT_EV_C0R] = c0_rise;
        ev[ECIT_EV_C0F] = c0_fall;
        ev[ECIT_EV_C1R] = wide ? c0_rise : c1_rise;
        ev[ECIT_EV_C1F] = wide ? c0_fall : c1_fall;
        ev = ev & ~(st_q.full & {4{hold}});
        pick = wide ? st_q.frc[7:0] : sel_bits(st_q.frc, st_q.cfg[ECIT_CFG_PRE_LSB +: 3]);
        if (ev[ECIT_EV_C0R])
        begin
            st_d.c0r = pick;
        end
        if (ev[ECIT_EV_C0F])
        begin
            st_d.c0f = pick;
        end
        if (ev[ECIT_EV_C1R])
        begin
            st_d.c1r = wide ? st_q.frc[15:8] : pick;
        end
        if (ev[ECIT_EV_C1F])
        begin
            st_d.c1f = wide ? st_q.frc[15:8] : pick;
        end
        st_d.full = (st_q.full & ~rd_clr) | ev;

        // Register writes
        st_d.bus = ECIT_BUS_IDLE;
        if (acc)
        begin
            st_d.bus = ECIT_BUS_ACK;
        end
        if (wr)
        begin
            case (i_avs_address[ECIT_ADDR_W-1:2])
                ECIT_IDX_C0_RISE:
                begin
                    st_d.c0r = wb;
                end
                ECIT_IDX_C0_FALL:
                begin
                    st_d.c0f = wb;
                end
                ECIT_IDX_C1_RISE:
                begin
                    st_d.c1r = wb;
                end
                ECIT_IDX_C1_FALL:
                begin
                    st_d.c1f = wb;
                end
                ECIT_IDX_RLD_LO:
                begin
                    st_d.rld_lo = wb;
                end
                ECIT_IDX_RLD_HI:
                begin
                    st_d.rld_hi = wb[3:0];
                end
                ECIT_IDX_CFG:
                begin
                    st_d.cfg = wb & ECIT_CFG_MASK;
                end
                ECIT_IDX_IRQ_EN:
                begin
                    st_d.irq_en = wb[3:0];
                end
                ECIT_IDX_PIT_EN:
                begin
                    st_d.pit_en = wb[0];
                end
                default:
                begin
                end
            endcase
        end

        // Sticky status: the set wins over a clear in the same cycle
        st_d.irq_st = st_q.irq_st;
        st_d.pit_st = st_q.pit_st;
        if (wr && is_idx(i_avs_address, ECIT_IDX_IRQ_ST))
        begin
            st_d.irq_st = st_q.irq_st & ~wb[3:0];
        end
        if (wr && is_idx(i_avs_address, ECIT_IDX_PIT_ST))
        begin
            st_d.pit_st = st_q.pit_st & ~wb[0];
        end
        st_d.irq_st = st_d.irq_st | ev;
        st_d.pit_st = st_d.pit_st | pit_expire;
        st_d.irq = |(st_q.irq_st & st_q.irq_en) | (st_q.pit_st & st_q.pit_en);

        // Read data, taken in the request cycle and shown in the acknowledge cycle
        if (rd)
        begin
            st_d.rdata = 32'h0000_0000;
            case (i_avs_address[ECIT_ADDR_W-1:2])
                ECIT_IDX_C0_RISE:
                begin
                    st_d.rdata[7:0] = st_q.c0r;
                end
                ECIT_IDX_C0_FALL:
                begin
                    st_d.rdata[7:0] = st_q.c0f;
                end
                ECIT_IDX_C1_RISE:
                begin
                    st_d.rdata[7:0] = st_q.c1r;
                end
                ECIT_IDX_C1_FALL:
                begin
                    st_d.rdata[7:0] = st_q.c1f;
                end
                ECIT_IDX_CNT_LO:
                begin
                    st_d.rdata[7:0] = pit_count[7:0];
                    st_d.held_nib = pit_count[11:8];
                end
                ECIT_IDX_CNT_HI:
                begin
                    st_d.rdata[3:0] = st_q.held_nib;
                end
                ECIT_IDX_RLD_LO:
                begin
                    st_d.rdata[7:0] = st_q.rld_lo;
                end
                ECIT_IDX_RLD_HI:
                begin
                    st_d.rdata[3:0] = st_q.rld_hi;
                end
                ECIT_IDX_CFG:
                begin
                    st_d.rdata[7:0] = st_q.cfg;
                end
                ECIT_IDX_IRQ_EN:
                begin
                    st_d.rdata[3:0] = st_q.irq_en;
                end
                ECIT_IDX_IRQ_ST:
                begin
                    st_d.rdata[3:0] = st_q.irq_st;
                end
                ECIT_IDX_PIT_EN:
                begin
                    st_d.rdata[0] = st_q.pit_en;
                end
                ECIT_IDX_PIT_ST:
                begin
                    st_d.rdata[0] = st_q.pit_st;
                end
                default:
                begin
                    st_d.rdata[7:0] = ECIT_UNMAPPED;
                end
            endcase
            if (i_avs_address[1:0] != 2'b00)
            begin
                st_d.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Waitrequest is low only in the acknowledge cycle
    assign o_avs_waitrequest = (st_q.bus != ECIT_BUS_ACK);
    assign o_avs_readdata = st_q.rdata;
    assign o_irq = st_q.irq;
endmodule // ecit_top

/* rtl/ecit_pkg.sv */
// Package for the edge capture and interval timer block.
// Assumes byte registers at word-aligned Avalon addresses (index times four).
package ecit_pkg;
    // ==========================================================
    // Register indices
    localparam logic [7:0] ECIT_IDX_C0_RISE = 8'h22;
    localparam logic [7:0] ECIT_IDX_C1_RISE = 8'h23;
    localparam logic [7:0] ECIT_IDX_C0_FALL = 8'h24;
    localparam logic [7:0] ECIT_IDX_C1_FALL = 8'h25;
    localparam logic [7:0] ECIT_IDX_CNT_LO = 8'h26;
    localparam logic [7:0] ECIT_IDX_CNT_HI = 8'h27;
    localparam logic [7:0] ECIT_IDX_RLD_LO = 8'h28;
    localparam logic [7:0] ECIT_IDX_RLD_HI = 8'h29;
    localparam logic [7:0] ECIT_IDX_CFG = 8'h2A;
    localparam logic [7:0] ECIT_IDX_IRQ_EN = 8'h2B;
    localparam logic [7:0] ECIT_IDX_IRQ_ST = 8'h2C;
    localparam logic [7:0] ECIT_IDX_PIT_EN = 8'h2D;
    localparam logic [7:0] ECIT_IDX_PIT_ST = 8'h2E;
    localparam int ECIT_ADDR_W = 10;
    // ==========================================================
    // Field positions and reset values
    localparam int ECIT_CFG_HOLD_BIT = 7;
    localparam int ECIT_CFG_PRE_LSB = 4;
    localparam int ECIT_CFG_WIDE_BIT = 3;
    localparam logic [7:0] ECIT_CFG_MASK = 8'hF8;
    localparam logic [7:0] ECIT_RESET_BYTE = 8'h00;
    localparam logic [7:0] ECIT_UNMAPPED = 8'h00;
    localparam int ECIT_EV_C0R = 0;
    localparam int ECIT_EV_C0F = 1;
    localparam int ECIT_EV_C1R = 2;
    localparam int ECIT_EV_C1F = 3;
    // ==========================================================
    // Timing
    localparam int ECIT_CLK_MHZ = 125;
    localparam int ECIT_CAP_CLK_DIV = 4;
    localparam int ECIT_PIT_DIV = 125;
    localparam int ECIT_PIT_W = 12;
    typedef enum logic [1:0] {
        ECIT_BUS_IDLE = 2'b00,
        ECIT_BUS_ACK = 2'b01
    } ecit_bus_e;
endpackage

/* rtl/ecit_edge_sync.sv */
// Synchroniser and edge detector for one capture input.
// Assumes the input is asynchronous to i_core_clk.
`timescale 1ns/1ps
module ecit_edge_sync
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ecit_sync_s;
    ecit_sync_s st_q;
    ecit_sync_s st_d;
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = i_pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    // Edges seen only from the second and third stages
    assign o_rise = st_q.s2 & ~st_q.s3;
    assign o_fall = ~st_q.s2 & st_q.s3;
endmodule // ecit_edge_sync

/* rtl/ecit_interval_timer.sv */
// 12-bit down-counting interval timer with reload.
// Assumes i_tick is a one-cycle enable from the core clock divider.
`timescale 1ns/1ps
module ecit_interval_timer
#(
    parameter int WIDTH = 12
)
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic [WIDTH-1:0] i_reload,
    output logic [WIDTH-1:0] o_count,
    output logic o_expire
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic expire;
    } ecit_pit_s;
    ecit_pit_s st_q;
    ecit_pit_s st_d;
    initial
    begin
        if (WIDTH < 2)
        begin
            $error("WIDTH too small");
        end
    end
    always_comb
    begin
        st_d = st_q;
        st_d.expire = 1'b0;
        if (i_tick)
        begin
            // Expire at zero and restart from the reload value
            if (st_q.count == '0)
            begin
                st_d.count = i_reload;
                st_d.expire = 1'b1;
            end
            else
            begin
                st_d.count = st_q.count - 1'b1;
            end
        end
    end
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    assign o_count = st_q.count;
    assign o_expire = st_q.expire;
endmodule // ecit_interval_timer

/* bench/ecit_pin_model.sv */
// Far-side model: drives the two capture pins.
// Assumes the bench requests levels on i_core_clk.
`timescale 1ns/1ps
module ecit_pin_model
(
    input wire logic i_core_clk,
    input wire logic [1:0] i_level,
    input wire logic [3:0] i_lag,
    output logic o_pin_zero,
    output logic o_pin_one
);
    // ==========================================
    // Pin drive
    logic [3:0] wait_q;
    initial
    begin
        o_pin_zero = 1'b0;
        o_pin_one = 1'b0;
        wait_q = 4'h0;
    end
    // A slow source holds the old level for i_lag cycles
    always @(posedge i_core_clk)
    begin
        if ({o_pin_one, o_pin_zero} == i_level)
            wait_q <= 4'h0;
        else if (wait_q >= i_lag)
        begin
            {o_pin_one, o_pin_zero} <= i_level;
            wait_q <= 4'h0;
        end
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule // ecit_pin_model

/* bench/ecit_checker.sv */
// Port checker for ecit_top.
// Assumes one clock domain and the bind in the bench top.
`timescale 1ns/1ps
module ecit_checker
import ecit_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [ECIT_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_irq
);
    // ==========================================
    // Bus and interrupt properties
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_take;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_rd_ack(logic [7:0] idx);
        i_avs_read && !o_avs_waitrequest && i_avs_address == {idx, 2'b00};
    endsequence
    a_ack_next: assert property (s_take |=> !o_avs_waitrequest)
        else $error("no answer one cycle after take");
    a_ack_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer longer than one cycle");
    a_ack_caused: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
        else $error("answer without request");
    a_rdata_hold: assert property ($changed(o_avs_readdata) |-> !o_avs_waitrequest && i_avs_read)
        else $error("read data moved outside a read answer");
    a_upper_zero: assert property (!o_avs_waitrequest && i_avs_read |-> o_avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_cnt_hi_res: assert property (s_rd_ack(ECIT_IDX_CNT_HI) |-> o_avs_readdata[7:4] == 4'h0)
        else $error("count high reserved bits set");
    a_status_res: assert property (s_rd_ack(ECIT_IDX_IRQ_ST) |-> o_avs_readdata[7:4] == 4'h0)
        else $error("status reserved bits set");
    a_cfg_res: assert property (s_rd_ack(ECIT_IDX_CFG) |-> o_avs_readdata[2:0] == 3'h0)
        else $error("config reserved bits set");
    a_irq_fall_write: assert property ($fell(o_irq) |-> $past(i_avs_write, 2)
        || $past(i_avs_write, 3) || $past(i_avs_write, 4))
        else $error("interrupt dropped without a write");
endmodule // ecit_checker

/* bench/ecit_top_tb.sv */
// Self-checking bench for ecit_top.
// Assumes a capture divider of 8, twice the default of 4, so counts stay small.
`timescale 1ns/1ps
module ecit_top_tb;
    import ecit_pkg::*;
    localparam int CAP = 8;
    localparam int LIMIT = 60000;
    logic clk, rst, rd_s, wr_s, wreq, irq, p0, p1;
    logic [ECIT_ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    logic [1:0] lvl;
    logic [3:0] lag;
    logic [7:0] rb, lo, d;
    int fail_count, num_checks, cyc, t0, tr;
    logic [7:0] ridx [5] = '{ECIT_IDX_C1_FALL, ECIT_IDX_RLD_LO, ECIT_IDX_RLD_HI, ECIT_IDX_CFG,
        ECIT_IDX_IRQ_EN};
    logic [7:0] rmsk [5] = '{8'hFF, 8'hFF, 8'h0F, 8'hF8, 8'h0F};
    ecit_top #(.CAP_DIV(CAP), .PIT_DIV(4)) u_ecit_top (.i_core_clk(clk), .i_reset(rst),
        .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_capture_input_zero(p0), .i_capture_input_one(p1), .o_irq(irq));
    ecit_pin_model u_ecit_pin_model (.i_core_clk(clk), .i_level(lvl), .i_lag(lag),
        .o_pin_zero(p0), .o_pin_one(p1));
    // ==========================================
    // Clock, timeout and checks
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= rst ? 0 : cyc + 1;
        if (cyc == LIMIT)
        begin
            fail("timeout");
            complete_run();
        end
    end
    task fail(input string m);
        fail_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task chk8(input logic [7:0] g, input logic [7:0] e, input string m);
        num_checks++;
        if (g !== e) fail(m);
    endtask
    // Pin-to-capture latency is not exact: one count of slack
    task chk_near(input logic [15:0] g, input logic [15:0] e, input logic [15:0] k,
        input string m);
        num_checks++;
        if (g !== (e & k) && g !== ((e + 16'h1) & k)) fail(m);
    endtask
    task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        addr <= {idx, 2'b00};
        rd_s <= !w;
        wr_s <= w;
        wdata <= {24'h0, wd};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (n >= 50) fail("no bus answer");
        rb = rdata[7:0];
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] wd);
        xfer(1'b1, idx, wd);
    endtask
    task rd(input logic [7:0] idx);
        xfer(1'b0, idx, 8'h00);
    endtask
    task pins(input logic [1:0] v);
        int n;
        lvl <= v;
        lag <= 4'($urandom_range(0, 5));
        n = 0;
        while ({p1, p0} !== v && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        t0 = cyc;
        repeat (8) @(posedge clk);
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    initial
    begin
        rst = 1'b1;
        rd_s = 1'b0;
        wr_s = 1'b0;
        addr = '0;
        wdata = '0;
        lvl = 2'b00;
        lag = 4'h0;
        fail_count = 0;
        num_checks = 0;
        cyc = 0;
        d = 8'($urandom(30117));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 8'h22; i <= 8'h2C; i++)
        begin
            rd(8'(i));
            chk8(rb, ECIT_RESET_BYTE, "reset value");
        end
        wr(ECIT_IDX_CNT_HI, 8'h0F);
        rd(ECIT_IDX_CNT_HI);
        chk8(rb, 8'h00, "count high took a write");
        wr(8'h30, 8'hFF);
        rd(8'h30);
        chk8(rb, ECIT_UNMAPPED, "unmapped");
        for (int i = 0; i < 5; i++)
        begin
            d = 8'($urandom);
            wr(ridx[i], d);
            rd(ridx[i]);
            chk8(rb, d & rmsk[i], "readback");
        end
        wr(ECIT_IDX_IRQ_EN, 8'h00);
        for (int n = 0; n < 8; n++)
        begin
            wr(ECIT_IDX_CFG, {1'b0, 3'(n), 4'h0});
            pins(2'b11);
            tr = t0;
            pins(2'b00);
            for (int k = 0; k < 4; k++)
            begin
                rd(8'(8'h22 + k));
                chk_near({8'h0, rb}, 16'(((k < 2 ? tr : t0) / CAP) >> n), 16'hFF, "capture");
            end
            rd(ECIT_IDX_IRQ_ST);
            chk8(rb, 8'h0F, "status set");
            chk8({7'h0, irq}, 8'h00, "irq while disabled");
            wr(ECIT_IDX_IRQ_ST, 8'h0F);
            rd(ECIT_IDX_IRQ_ST);
            chk8(rb, 8'h00, "status clear");
        end
        repeat (3000) @(posedge clk);
        wr(ECIT_IDX_CFG, 8'h08);
        pins(2'b11);
        tr = t0;
        pins(2'b00);
        rd(ECIT_IDX_C0_RISE);
        lo = rb;
        rd(ECIT_IDX_C1_RISE);
        chk_near({rb, lo}, 16'(tr / CAP), 16'hFFFF, "wide rise");
        rd(ECIT_IDX_C0_FALL);
        lo = rb;
        rd(ECIT_IDX_C1_FALL);
        chk_near({rb, lo}, 16'(t0 / CAP), 16'hFFFF, "wide fall");
        wr(ECIT_IDX_IRQ_ST, 8'h0F);
        pins(2'b10);
        pins(2'b00);
        rd(ECIT_IDX_IRQ_ST);
        chk8(rb, 8'h00, "channel one not disabled");
        for (int h = 0; h < 2; h++)
        begin
            wr(ECIT_IDX_CFG, {1'(h), 7'h0});
            pins(2'b01);
            tr = t0;
            pins(2'b00);
            pins(2'b01);
            rd(ECIT_IDX_C0_RISE);
            chk_near({8'h0, rb}, 16'(((h == 1) ? tr : t0) / CAP), 16'hFF, "hold");
            pins(2'b00);
            pins(2'b01);
            rd(ECIT_IDX_C0_RISE);
            chk_near({8'h0, rb}, 16'(t0 / CAP), 16'hFF, "rearm");
            pins(2'b00);
        end
        wr(ECIT_IDX_CFG, 8'h00);
        for (int b = 0; b < 4; b++)
        begin
            wr(ECIT_IDX_IRQ_ST, 8'h0F);
            wr(ECIT_IDX_IRQ_EN, 8'(1 << b));
            pins(2'b11);
            pins(2'b00);
            chk8({7'h0, irq}, 8'h01, "irq raise");
            wr(ECIT_IDX_IRQ_EN, 8'h00);
            repeat (2) @(posedge clk);
            chk8({7'h0, irq}, 8'h00, "irq mask");
            wr(ECIT_IDX_IRQ_EN, 8'(1 << b));
            wr(ECIT_IDX_IRQ_ST, 8'(1 << b));
            repeat (2) @(posedge clk);
            chk8({7'h0, irq}, 8'h00, "irq clear");
            rd(ECIT_IDX_IRQ_ST);
            chk8(rb, 8'h0F & ~8'(1 << b), "other status kept");
        end
        wr(ECIT_IDX_IRQ_EN, 8'h00);
        wr(ECIT_IDX_IRQ_ST, 8'h0F);
        d = 8'($urandom_range(3, 9));
        wr(ECIT_IDX_RLD_LO, d);
        wr(ECIT_IDX_RLD_HI, 8'h01);
        wr(ECIT_IDX_PIT_EN, 8'h01);
        wr(ECIT_IDX_PIT_ST, 8'h01);
        // One expiry after the reload writes puts the long period in use
        tr = 0;
        do
        begin
            @(posedge clk);
            tr++;
        end
        while (irq !== 1'b1 && tr < 20000);
        wr(ECIT_IDX_PIT_ST, 8'h01);
        rd(ECIT_IDX_PIT_ST);
        chk8(rb, 8'h00, "interval status clear");
        chk8({7'h0, irq}, 8'h00, "interval irq clear");
        repeat (1100) @(posedge clk);
        rd(ECIT_IDX_PIT_ST);
        chk8(rb, 8'h01, "interval expiry");
        chk8({7'h0, irq}, 8'h01, "interval irq");
        rd(ECIT_IDX_CNT_LO);
        lo = rb;
        rd(ECIT_IDX_CNT_HI);
        chk8(8'({rb[3:0], lo} <= {4'h1, d}), 8'h01, "count range");
        wr(ECIT_IDX_PIT_EN, 8'h00);
        complete_run();
    end
endmodule // ecit_top_tb
bind ecit_top ecit_checker u_ecit_checker (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq));
